// ===== dv/ctb_link_sva.sv
// assertions on the host-device block transfer link
`timescale 1ns/1ns
`default_nettype none
module ctb_link_sva
	import ctb_pkg::*;
(
	// clock and reset
	input wire logic      core_clk,
	input wire logic      srst,
	// link signals
	input wire ctb_word_t word3,
	input wire ctb_word_t inWord0,
	input wire logic      btwStart,
	input wire logic      btrStart,
	input wire ctb_word_t hData,
	input wire logic      hValid,
	input wire ctb_word_t dData,
	input wire logic      dValid,
	input wire logic      btDone
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic       inXfer_r;
	logic       wrMode_r;
	logic [6:0] cnt_r;

	// ==================================================================
	// helper state
	// ==================================================================
	// open transfer, its direction and words moved so far
	always_ff @(posedge core_clk) begin
		if (srst || btDone) inXfer_r <= 1'b0;
		else if (btwStart || btrStart) inXfer_r <= 1'b1;
	end
	always_ff @(posedge core_clk) begin
		if (srst || btrStart) wrMode_r <= 1'b0;
		else if (btwStart) wrMode_r <= 1'b1;
	end
	always_ff @(posedge core_clk) begin
		if (srst || btwStart || btrStart) cnt_r <= 7'h00;
		else if (hValid || dValid) cnt_r <= cnt_r + 7'h01;
	end

	// ==================================================================
	// checks
	// ==================================================================
	a_busy_on_write: assert property (btwStart |-> ##[1:3] inWord0[4])
		else $error("busy not raised by block write");
	a_dv_cleared: assert property (btwStart && word3[1]
		|-> ##[1:3] inWord0[7:6] == 2'b00) else $error("data valid kept");
	a_busy_on_tpl: assert property (btrStart && word3[5]
		|-> ##[1:3] inWord0[4]) else $error("busy not raised by template");
	a_read_burst: assert property (btrStart && word3[1]
		&& word3[15:8] < 8'h08 |-> ##2 dValid [*8])
		else $error("read burst late or broken");
	a_word_count: assert property (btDone
		|-> cnt_r + (hValid | dValid) == 64) else $error("block not 64 words");
	a_word3_held: assert property ((btwStart || inXfer_r) && !btDone
		|=> $stable(word3)) else $error("word 3 moved in transfer");
	a_busy_release: assert property (btDone && wrMode_r && word3[3]
		|-> ##[2:8] !inWord0[4]) else $error("busy stuck after last block");
	a_dv_frozen: assert property (inWord0[4] && $past(inWord0[4])
		|-> (inWord0[7:6] & ~$past(inWord0[7:6])) == 2'b00)
		else $error("data valid set while busy");
	// main scenarios
	c_last_write: cover property (btwStart && word3[3]);
	c_tpl_read: cover property (btrStart && word3[5]);
	c_fault: cover property ($rose(inWord0[5]));
endmodule // ctb_link_sva
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the block transfer link
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import ctb_pkg::*;
	logic       core_clk, srst, cmdStart, cmdWrite, cmdTpl, cmdLast;
	logic       tplUpload, ldEn, runMode, busy, localIoEn, setupMenuEn;
	logic       cfgFault, cfgCommit, rdValid, cmdDone, hostBusy;
	logic       resultsNew, busyD;
	logic [1:0] trigIn, resultReady, trigOut, dataValid;
	logic [7:0] cmdBlk, rdBlk;
	logic [5:0] ldIdx, rdIdx;
	ctb_word_t  ldData, rdData;
	ctb_word_t  rdMem [0:1023];
	int         failures, compares, rdCnt, commitCnt, newCnt, trigBad;
	int         cycles, n0;

	// ==================================================================
	// design and checker
	// ==================================================================
	ctb_link_if link ();
	ctb_cfg_loader ctb_cfg_loader_i (.core_clk, .srst, .link, .trigIn,
		.resultReady, .trigOut, .dataValid, .runMode, .busy, .localIoEn,
		.setupMenuEn, .cfgFault, .cfgCommit);
	ctb_host_ctl ctb_host_ctl_i (.core_clk, .srst, .link, .cmdStart,
		.cmdWrite, .cmdTpl, .cmdBlk, .cmdLast, .tplUpload, .ldEn, .ldIdx,
		.ldData, .rdValid, .rdBlk, .rdIdx, .rdData, .cmdDone, .hostBusy,
		.resultsNew);
	ctb_link_sva ctb_link_sva_i (.core_clk(core_clk), .srst(srst),
		.word3(link.word3), .inWord0(link.inWord0),
		.btwStart(link.btwStart), .btrStart(link.btrStart),
		.hData(link.hData), .hValid(link.hValid), .dData(link.dData),
		.dValid(link.dValid), .btDone(link.btDone));

	// ==================================================================
	// clock, monitors and hang limit
	// ==================================================================
	always #2 core_clk = ~core_clk;
	// capture read words, count events, cut a hang short
	always @(posedge core_clk) begin
		busyD <= busy;
		if (rdValid === 1'b1) begin
			rdMem[{rdBlk[3:0], rdIdx}] <= rdData;
			rdCnt++;
		end
		if (cfgCommit === 1'b1) commitCnt++;
		if (resultsNew === 1'b1) newCnt++;
		if (busy === 1'b1 && busyD === 1'b1 && trigOut !== 2'b00) trigBad++;
		cycles++;
		if (cycles == 10000) begin
			failures++;
			test_done();
		end
	end

	// ==================================================================
	// tasks
	// ==================================================================
	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] got, exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	function automatic ctb_word_t wd(input logic [7:0] b, s,
		input ctb_word_t w0, w1, input int i);
		return i == 0 ? w0 : i == 1 ? w1 : {s ^ b, 2'b00, i[5:0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// fill the host write buffer with one block
	task automatic load(input logic [7:0] b, s, input ctb_word_t w0, w1);
		for (int i = 0; i < 64; i++) begin
			@(negedge core_clk);
			ldEn = 1'b1;
			ldIdx = i[5:0];
			ldData = wd(b, s, w0, w1, i);
		end
		@(negedge core_clk);
		ldEn = 1'b0;
	endtask
	task automatic waitDone();
		int n = 0;
		while (cmdDone !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
		end
		tick(8);
	endtask
	task automatic cmd(input logic w, t, input logic [7:0] b, input logic l);
		@(negedge core_clk);
		{cmdWrite, cmdTpl, cmdBlk, cmdLast, cmdStart} = {w, t, b, l, 1'b1};
		@(negedge core_clk);
		cmdStart = 1'b0;
		waitDone();
	endtask
	task automatic rdchk(input logic [7:0] b, s, input ctb_word_t w0, w1);
		for (int i = 0; i < 64; i++)
			check("rd", rdMem[{b[3:0], i[5:0]}], wd(b, s, w0, w1, i));
	endtask

	// ==================================================================
	// main sequence
	// ==================================================================
	initial begin
		{core_clk, srst, cmdStart, cmdWrite, cmdTpl, cmdLast} = 6'h10;
		{tplUpload, ldEn, ldIdx, ldData, cmdBlk} = '0;
		{trigIn, resultReady} = 4'h0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		srst = 1'b0;
		tick(1);
		check("inWord0", link.inWord0, 16'h0000);
		check("run", {runMode, localIoEn, setupMenuEn}, 3'b111);
		// results flag, then a trigger in run
		@(negedge core_clk);
		resultReady = 2'b10;
		@(negedge core_clk);
		resultReady = 2'b00;
		tick(4);
		check("dvWord", link.inWord0[7:6], 2'b10);
		check("dataValid", dataValid, 2'b10);
		@(negedge core_clk);
		trigIn = 2'b01;
		tick(1);
		check("trigOut", trigOut, 2'b01);
		@(negedge core_clk);
		trigIn = 2'b11;
		// config session, good commit, bad commit
		load(8'h03, 8'h11, 16'h0003, 16'h1234);
		cmd(1'b1, 1'b0, 8'h03, 1'b0);
		check("sess", {busy, runMode, localIoEn, setupMenuEn}, 4'h8);
		check("sessWord", link.inWord0[7:4], 4'h1);
		load(8'h05, 8'h11, 16'h0005, 16'h1234);
		cmd(1'b1, 1'b0, 8'h05, 1'b1);
		check("done", {busy, runMode, cfgFault}, 3'b010);
		check("commits", 16'(commitCnt), 16'h0001);
		cmd(1'b0, 1'b0, 8'h05, 1'b0);
		rdchk(8'h05, 8'h11, 16'h0005, 16'h1234);
		cmd(1'b0, 1'b0, 8'h03, 1'b0);
		rdchk(8'h03, 8'h11, 16'h0003, 16'h1234);
		load(8'h05, 8'h22, 16'h0009, 16'h4321);
		cmd(1'b1, 1'b0, 8'h05, 1'b1);
		check("fault", {cfgFault, link.inWord0[5]}, 2'b11);
		check("commits", 16'(commitCnt), 16'h0001);
		cmd(1'b0, 1'b0, 8'h05, 1'b0);
		rdchk(8'h05, 8'h11, 16'h0005, 16'h1234);
		// template download of three blocks, then full upload
		load(8'h00, 8'h33, 16'h00A0, 16'h0300);
		cmd(1'b1, 1'b1, 8'h00, 1'b0);
		load(8'h01, 8'h33, 16'h00A1, 16'h0001);
		cmd(1'b1, 1'b1, 8'h01, 1'b0);
		load(8'h02, 8'h33, 16'h00A2, 16'h0002);
		cmd(1'b1, 1'b1, 8'h02, 1'b0);
		check("tplFault", cfgFault, 1'b0);
		n0 = rdCnt;
		@(negedge core_clk);
		tplUpload = 1'b1;
		@(negedge core_clk);
		tplUpload = 1'b0;
		waitDone();
		check("upWords", 16'(rdCnt - n0), 16'd192);
		rdchk(8'h00, 8'h33, 16'h00A0, 16'h0300);
		rdchk(8'h01, 8'h33, 16'h00A1, 16'h0001);
		rdchk(8'h02, 8'h33, 16'h00A2, 16'h0002);
		// failed template download loses the set
		load(8'h00, 8'h44, 16'h00A0, 16'h0000);
		cmd(1'b1, 1'b1, 8'h00, 1'b1);
		check("tplBad", cfgFault, 1'b1);
		cmd(1'b0, 1'b1, 8'h00, 1'b0);
		check("tplCnt", rdMem[10'h001][15:8], 8'h00);
		check("trigBusy", 16'(trigBad), 16'h0000);
		check("newRes", 16'(newCnt), 16'h0001);
		test_done();
	end
endmodule // testbench
`default_nettype wire

// ===== logic/ctb_cfg_loader.sv
// device end: receives, validates and serves configuration/template blocks
// ==========================================================================
// What this block does
// - config receive: leave run, busy, outputs quiet
// - validate whole configuration after last block
// - failed validation: discard, fault, keep old
// - host sets config bit with transfer
// - block number field selects the block
// - last flag ends session; no timeout
// - template store holds 100 blocks of 64
// - host moves templates unchanged, whole set
// - template transfer: leave run, ignore triggers, busy, except between upload blocks
// - first template block word1 reports count
// - host upload reads first, then count-1 more
// - host download sends count blocks
// - failed template download loses all templates
// - host may poll trigger count for results; no trigger count is kept here
// - host may watch data valid instead
// - data valid bits 6 and 7 per toolset
// ==========================================================================
`include "ctb_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ctb_cfg_loader
	import ctb_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// link to the host
	ctb_link_if.dev         link,
	// inspection side
	input  wire logic [1:0] trigIn,
	input  wire logic [1:0] resultReady,
	output logic      [1:0] trigOut,
	output logic      [1:0] dataValid,
	output logic            runMode,
	output logic            busy,
	output logic            localIoEn,
	output logic            setupMenuEn,
	output logic            cfgFault,
	output logic            cfgCommit
);

	// ======================================================================
	// storage
	// ======================================================================
	ctb_word_t  cfgMem [0:`CTB_CFG_DEPTH-1];
	ctb_word_t  tplMem [0:`CTB_TPL_DEPTH-1];

	ctb_state_e state_r;
	logic       xCfg_r;
	logic       xTpl_r;
	logic       xLast_r;
	logic [7:0] xBlk_r;
	logic [5:0] idx_r;
	logic       sess_r;
	logic [7:0] cfgAct_r;
	logic [7:0] cfgWr_r;
	logic [7:0] cfgOk_r;
	logic       badBlk_r;
	logic       tplAny_r;
	logic       tplSeen0_r;
	logic [7:0] tplExp_r;
	logic [7:0] tplRxCnt_r;
	logic [7:0] tplCount_r;
	logic [1:0] trigOut_r;
	logic [1:0] dv_r;
	logic       runMode_r;
	logic       busy_r;
	logic       quiet_r;
	logic       cfgFault_r;
	logic       cfgCommit_r;
	ctb_word_t  inWord0_r;
	ctb_word_t  dData_r;
	logic       dValid_r;
	logic       btDone_r;

	logic       startAny;
	logic       cfgBlkOk;
	logic       tplBlkOk;
	logic       wrWord;
	logic       wrLast;
	logic       cfgPass;
	logic       tplPass;
	logic       rxCfg;
	logic [9:0] cfgWrAddr;
	logic [9:0] cfgRdAddr;
	logic [12:0] tplAddr;

	// ======================================================================
	// decode of the latched transfer
	// ======================================================================
	assign startAny  = link.btwStart | link.btrStart;
	assign cfgBlkOk  = xCfg_r & (xBlk_r < `CTB_CFG_BLOCKS);
	assign tplBlkOk  = xTpl_r & (xBlk_r < `CTB_TPL_BLOCKS);
	assign wrWord    = (state_r == ST_WR) & link.hValid;
	assign wrLast    = wrWord & (idx_r == `CTB_LAST_IDX);
	assign rxCfg     = sess_r | (state_r == ST_WR);
	assign cfgWrAddr = {~cfgAct_r[xBlk_r[2:0]], xBlk_r[2:0], idx_r};
	assign cfgRdAddr = {cfgAct_r[xBlk_r[2:0]], xBlk_r[2:0], idx_r};
	assign tplAddr   = {xBlk_r[6:0], idx_r};

	// whole-set checks used in the validate step
	assign cfgPass = ~badBlk_r & (&(~cfgWr_r | cfgOk_r));
	assign tplPass = ~tplAny_r | (tplSeen0_r & (tplExp_r != 8'h00) &
		(tplExp_r <= `CTB_TPL_BLOCKS) & (tplRxCnt_r == tplExp_r));

	// ======================================================================
	// sequencer
	// ======================================================================
	// one block at a time; a session waits for the last flag forever
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= ST_RUN;
		end else begin
			case (state_r)
				ST_RUN, ST_SESS: begin
					if (link.btwStart) begin
						state_r <= ST_WR;
					end else if (link.btrStart) begin
						state_r <= ST_RD;
					end
				end
				ST_WR: begin
					if (wrLast) begin
						state_r <= xLast_r ? ST_VAL : ST_SESS;
					end
				end
				ST_RD: begin
					if (idx_r == `CTB_LAST_IDX) begin
						state_r <= sess_r ? ST_SESS : ST_RUN;
					end
				end
				ST_VAL: begin
					state_r <= ST_RUN;
				end
				default: begin
					state_r <= ST_RUN;
				end
			endcase
		end
	end

	// transfer fields captured at start, frozen until done
	always_ff @(posedge core_clk) begin
		if (srst) begin
			xCfg_r  <= 1'b0;
			xTpl_r  <= 1'b0;
			xLast_r <= 1'b0;
			xBlk_r  <= 8'h00;
		end else if (startAny &&
			(state_r == ST_RUN || state_r == ST_SESS)) begin
			xCfg_r  <= link.word3[`CTB_W3_CFG_BIT];
			xTpl_r  <= link.word3[`CTB_W3_TPL_BIT];
			xLast_r <= link.word3[`CTB_W3_LAST_BIT];
			xBlk_r  <= link.word3[`CTB_W3_BLK_MSB:`CTB_W3_BLK_LSB];
		end
	end

	// word counter within a block
	always_ff @(posedge core_clk) begin
		if (srst) begin
			idx_r <= 6'h00;
		end else if (state_r == ST_RUN || state_r == ST_SESS) begin
			idx_r <= 6'h00;
		end else if (wrWord || state_r == ST_RD) begin
			idx_r <= idx_r + 6'h01;
		end
	end

	// session flag: set by any block write, ended by validation
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sess_r <= 1'b0;
		end else if (link.btwStart && state_r != ST_WR) begin
			sess_r <= 1'b1;
		end else if (state_r == ST_VAL) begin
			sess_r <= 1'b0;
		end
	end

	// ======================================================================
	// block storage writes; new config goes to the idle bank
	// ======================================================================
	always_ff @(posedge core_clk) begin
		if (wrWord && cfgBlkOk) begin
			cfgMem[cfgWrAddr] <= link.hData;
		end
		if (wrWord && tplBlkOk) begin
			tplMem[tplAddr] <= link.hData;
		end
	end

	// per-block bookkeeping for the config banks
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfgAct_r <= 8'h00;
			cfgWr_r  <= 8'h00;
			cfgOk_r  <= 8'h00;
		end else if (state_r == ST_VAL) begin
			if (cfgPass && tplPass) begin
				cfgAct_r <= cfgAct_r ^ cfgWr_r;
			end
			cfgWr_r <= 8'h00;
			cfgOk_r <= 8'h00;
		end else if (wrWord && cfgBlkOk && idx_r == 6'h00) begin
			// header word must carry its own block number
			cfgWr_r[xBlk_r[2:0]] <= 1'b1;
			cfgOk_r[xBlk_r[2:0]] <= (link.hData == {8'h00, xBlk_r});
		end
	end

	// out-of-range or ambiguous block marks the session bad
	always_ff @(posedge core_clk) begin
		if (srst) begin
			badBlk_r <= 1'b0;
		end else if (state_r == ST_VAL) begin
			badBlk_r <= 1'b0;
		end else if (wrWord && idx_r == 6'h00 &&
			((xCfg_r == xTpl_r) || !(cfgBlkOk || tplBlkOk))) begin
			badBlk_r <= 1'b1;
		end
	end

	// template set tracking for the session
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tplAny_r   <= 1'b0;
			tplSeen0_r <= 1'b0;
			tplExp_r   <= 8'h00;
			tplRxCnt_r <= 8'h00;
		end else if (state_r == ST_VAL) begin
			tplAny_r   <= 1'b0;
			tplSeen0_r <= 1'b0;
			tplRxCnt_r <= 8'h00;
		end else if (wrWord && tplBlkOk) begin
			tplAny_r <= 1'b1;
			if (xBlk_r == 8'h00 && idx_r == `CTB_CNT_WORD) begin
				tplSeen0_r <= 1'b1;
				tplExp_r   <= link.hData[`CTB_CNT_MSB:`CTB_CNT_LSB];
			end
			if (idx_r == `CTB_LAST_IDX) begin
				tplRxCnt_r <= tplRxCnt_r + 8'h01;
			end
		end
	end

	// verdict: commit both, or keep old config and drop templates if the session sent any
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tplCount_r  <= 8'h00;
			cfgFault_r  <= 1'b0;
			cfgCommit_r <= 1'b0;
		end else begin
			cfgCommit_r <= (state_r == ST_VAL) & cfgPass & tplPass;
			if (state_r == ST_VAL) begin
				cfgFault_r <= ~(cfgPass & tplPass);
				if (tplAny_r) begin
					// a failed download leaves no templates at all
					tplCount_r <= (cfgPass & tplPass) ? tplExp_r
						: 8'h00;
				end
			end
		end
	end

	// ======================================================================
	// block reads back to the host
	// ======================================================================
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dData_r  <= 16'h0000;
			dValid_r <= 1'b0;
			btDone_r <= 1'b0;
		end else begin
			dValid_r <= (state_r == ST_RD);
			btDone_r <= wrLast |
				((state_r == ST_RD) & (idx_r == `CTB_LAST_IDX));
			if (state_r != ST_RD) begin
				dData_r <= 16'h0000;
			end else if (tplBlkOk && xBlk_r == 8'h00 &&
				idx_r == `CTB_CNT_WORD) begin
				dData_r <= {tplCount_r, tplMem[tplAddr][7:0]};
			end else if (tplBlkOk) begin
				dData_r <= tplMem[tplAddr];
			end else if (cfgBlkOk) begin
				dData_r <= cfgMem[cfgRdAddr];
			end else begin
				dData_r <= 16'h0000;
			end
		end
	end

	// ======================================================================
	// inspection side: triggers and data valid per toolset
	// ======================================================================
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gTs
			always_ff @(posedge core_clk) begin
				if (srst) begin
					trigOut_r[g] <= 1'b0;
					dv_r[g]      <= 1'b0;
				end else begin
					trigOut_r[g] <= trigIn[g] & (state_r == ST_RUN);
					if (resultReady[g] && state_r == ST_RUN) begin
						dv_r[g] <= 1'b1;
					end else if (rxCfg || (trigIn[g] &&
						state_r == ST_RUN)) begin
						dv_r[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// mode and status flags follow the sequencer by one cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			runMode_r <= 1'b1;
			busy_r    <= 1'b0;
			quiet_r   <= 1'b0;
			inWord0_r <= 16'h0000;
		end else begin
			runMode_r <= (state_r == ST_RUN);
			busy_r    <= (state_r != ST_RUN);
			quiet_r   <= rxCfg;
			inWord0_r <= 16'h0000;
			inWord0_r[`CTB_W0_BUSY_BIT]  <= (state_r != ST_RUN);
			inWord0_r[`CTB_W0_FAULT_BIT] <= cfgFault_r;
			inWord0_r[`CTB_W0_DV1_BIT]   <= dv_r[0];
			inWord0_r[`CTB_W0_DV2_BIT]   <= dv_r[1];
		end
	end

	// port drive
	assign trigOut      = trigOut_r;
	assign dataValid    = dv_r;
	assign runMode      = runMode_r;
	assign busy         = busy_r;
	assign localIoEn    = ~quiet_r;
	assign setupMenuEn  = ~quiet_r;
	assign cfgFault     = cfgFault_r;
	assign cfgCommit    = cfgCommit_r;
	assign link.inWord0 = inWord0_r;
	assign link.dData   = dData_r;
	assign link.dValid  = dValid_r;
	assign link.btDone  = btDone_r;

endmodule // ctb_cfg_loader
`default_nettype wire

// ===== logic/ctb_host_ctl.sv
// host end: drives word 3 and moves 64-word blocks to and from the device
`include "ctb_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ctb_host_ctl
	import ctb_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// link to the device
	ctb_link_if.host        link,
	// block command from the user
	input  wire logic       cmdStart,
	input  wire logic       cmdWrite,
	input  wire logic       cmdTpl,
	input  wire logic [7:0] cmdBlk,
	input  wire logic       cmdLast,
	input  wire logic       tplUpload,
	// write buffer load
	input  wire logic       ldEn,
	input  wire logic [5:0] ldIdx,
	input  wire ctb_word_t  ldData,
	// read data and status to the user
	output logic            rdValid,
	output logic      [7:0] rdBlk,
	output logic      [5:0] rdIdx,
	output ctb_word_t       rdData,
	output logic            cmdDone,
	output logic            hostBusy,
	output logic            resultsNew
);

	// ======================================================================
	// state
	// ======================================================================
	ctb_word_t   wrBuf [0:`CTB_BLK_WORDS-1];
	ctb_hstate_e hs_r;
	ctb_word_t   word3_r;
	logic        btw_r;
	logic        btr_r;
	ctb_word_t   hData_r;
	logic        hValid_r;
	logic [5:0]  idx_r;
	logic        upl_r;
	logic [7:0]  uplCnt_r;
	logic [7:0]  dlCnt_r;
	logic        rdValid_r;
	logic [5:0]  rdIdx_r;
	logic [7:0]  rdBlk_r;
	ctb_word_t   rdData_r;
	logic        cmdDone_r;
	logic [1:0]  dvPrev_r;
	logic        resNew_r;

	logic [7:0]  dlCnt;
	logic        autoLast;
	logic        more;

	// template download count comes from block 0 word 1
	assign dlCnt    = (cmdBlk == 8'h00) ?
		wrBuf[`CTB_CNT_WORD][`CTB_CNT_MSB:`CTB_CNT_LSB] : dlCnt_r;
	assign autoLast = cmdTpl & cmdWrite & (cmdBlk == dlCnt - 8'h01);
	assign more     = upl_r & (word3_r[15:8] + 8'h01 < uplCnt_r);

	// user loads the outgoing block unchanged
	always_ff @(posedge core_clk) begin
		if (ldEn) begin
			wrBuf[ldIdx] <= ldData;
		end
	end

	// ======================================================================
	// command sequencer
	// ======================================================================
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hs_r      <= HS_IDLE;
			word3_r   <= `CTB_W3_RESET;
			btw_r     <= 1'b0;
			btr_r     <= 1'b0;
			upl_r     <= 1'b0;
			dlCnt_r   <= 8'h00;
			cmdDone_r <= 1'b0;
		end else begin
			btw_r     <= 1'b0;
			btr_r     <= 1'b0;
			cmdDone_r <= 1'b0;
			case (hs_r)
				HS_IDLE: begin
					if (tplUpload) begin
						word3_r <= 16'h0000;
						word3_r[`CTB_W3_TPL_BIT] <= 1'b1;
						upl_r <= 1'b1;
						btr_r <= 1'b1;
						hs_r  <= HS_WAIT;
					end else if (cmdStart) begin
						word3_r <= {cmdBlk, 8'h00};
						word3_r[`CTB_W3_CFG_BIT]  <= ~cmdTpl;
						word3_r[`CTB_W3_TPL_BIT]  <= cmdTpl;
						word3_r[`CTB_W3_LAST_BIT] <= cmdLast | autoLast;
						if (cmdTpl && cmdWrite) begin
							dlCnt_r <= dlCnt;
						end
						btw_r <= cmdWrite;
						btr_r <= ~cmdWrite;
						hs_r  <= cmdWrite ? HS_WR : HS_WAIT;
					end
				end
				HS_WR: begin
					if (idx_r == `CTB_LAST_IDX) begin
						hs_r <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (link.btDone && more) begin
						word3_r[15:8] <= word3_r[15:8] + 8'h01;
						btr_r <= 1'b1;
					end else if (link.btDone) begin
						upl_r     <= 1'b0;
						cmdDone_r <= 1'b1;
						hs_r      <= HS_IDLE;
					end
				end
				default: begin
					hs_r <= HS_IDLE;
				end
			endcase
		end
	end

	// outgoing words, one per cycle, from the cycle after the start
	always_ff @(posedge core_clk) begin
		if (srst) begin
			idx_r    <= 6'h00;
			hData_r  <= 16'h0000;
			hValid_r <= 1'b0;
		end else begin
			hValid_r <= (hs_r == HS_WR);
			hData_r  <= (hs_r == HS_WR) ? wrBuf[idx_r] : 16'h0000;
			idx_r    <= (hs_r == HS_WR) ? idx_r + 6'h01 : 6'h00;
		end
	end

	// incoming words; upload count taken from block 0 word 1
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdValid_r <= 1'b0;
			rdIdx_r   <= 6'h00;
			rdBlk_r   <= 8'h00;
			rdData_r  <= 16'h0000;
			uplCnt_r  <= 8'h00;
		end else begin
			rdValid_r <= link.dValid;
			// block number travels with its word, not the next request
			rdBlk_r   <= word3_r[15:8];
			rdData_r  <= link.dData;
			if (rdValid_r) begin
				rdIdx_r <= rdIdx_r + 6'h01;
			end
			if (link.dValid && upl_r && word3_r[15:8] == 8'h00 &&
				(rdIdx_r + {5'h00, rdValid_r}) == `CTB_CNT_WORD) begin
				uplCnt_r <= link.dData[`CTB_CNT_MSB:`CTB_CNT_LSB];
			end
		end
	end

	// new results seen as a rising data valid bit
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dvPrev_r <= 2'b00;
			resNew_r <= 1'b0;
		end else begin
			dvPrev_r <= {link.inWord0[`CTB_W0_DV2_BIT],
				link.inWord0[`CTB_W0_DV1_BIT]};
			resNew_r <= |({link.inWord0[`CTB_W0_DV2_BIT],
				link.inWord0[`CTB_W0_DV1_BIT]} & ~dvPrev_r);
		end
	end

	// port drive
	assign link.word3    = word3_r;
	assign link.btwStart = btw_r;
	assign link.btrStart = btr_r;
	assign link.hData    = hData_r;
	assign link.hValid   = hValid_r;
	assign rdValid       = rdValid_r;
	assign rdBlk         = rdBlk_r;
	assign rdIdx         = rdIdx_r;
	assign rdData        = rdData_r;
	assign cmdDone       = cmdDone_r;
	assign hostBusy      = (hs_r != HS_IDLE);
	assign resultsNew    = resNew_r;

endmodule // ctb_host_ctl
`default_nettype wire

// ===== logic/ctb_link_if.sv
// discrete words and block transfer strobes between host and device
`timescale 1ns/1ns
`default_nettype none
interface ctb_link_if;
	import ctb_pkg::*;
	ctb_word_t word3;     // discrete output word 3
	ctb_word_t inWord0;   // discrete input word 0
	logic      btwStart;  // block write begins
	logic      btrStart;  // block_read_request
	ctb_word_t hData;     // host write data
	logic      hValid;
	ctb_word_t dData;     // device read data
	logic      dValid;
	logic      btDone;    // block transfer complete

	modport dev (
		input  word3, btwStart, btrStart, hData, hValid,
		output inWord0, dData, dValid, btDone
	);
	modport host (
		output word3, btwStart, btrStart, hData, hValid,
		input  inWord0, dData, dValid, btDone
	);
endinterface
`default_nettype wire

// ===== logic/ctb_pkg.sv
// types shared by both ends of the block transfer link
`default_nettype none
package ctb_pkg;

	typedef logic [15:0] ctb_word_t;

	// device sequencing states
	typedef enum logic [2:0] {
		ST_RUN  = 3'b000,
		ST_SESS = 3'b001,
		ST_WR   = 3'b010,
		ST_RD   = 3'b011,
		ST_VAL  = 3'b100
	} ctb_state_e;

	// host sequencing states
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_WR   = 2'b01,
		HS_WAIT = 2'b10
	} ctb_hstate_e;

endpackage
`default_nettype wire

// ===== logic/ctb_regs.svh
// constants for the configuration and template block transfer link
`ifndef CTB_REGS_SVH
`define CTB_REGS_SVH

// ==========================================================================
// discrete output word 3 (host to device), bit positions
// ==========================================================================
`define CTB_W3_CFG_BIT    1
`define CTB_W3_LAST_BIT   3
`define CTB_W3_TPL_BIT    5
`define CTB_W3_BLK_LSB    8
`define CTB_W3_BLK_MSB    15
`define CTB_W3_RESET      16'h0000

// ==========================================================================
// discrete input word 0 (device to host), bit positions
// ==========================================================================
`define CTB_W0_BUSY_BIT   4
`define CTB_W0_FAULT_BIT  5
`define CTB_W0_DV1_BIT    6
`define CTB_W0_DV2_BIT    7

// ==========================================================================
// block geometry and storage
// ==========================================================================
`define CTB_BLK_WORDS     64
`define CTB_LAST_IDX      6'h3F
`define CTB_CFG_BLOCKS    8'h08
`define CTB_TPL_BLOCKS    8'h64
`define CTB_TPL_DEPTH     6400
`define CTB_CFG_DEPTH     1024
`define CTB_CNT_WORD      6'h01
`define CTB_CNT_LSB       8
`define CTB_CNT_MSB       15

`endif
